// >>> src/sso_top.sv
// Functional notes
// - NFET gate code 010 off, 001 on.
// - PFET gate code 100 on, 010 off.
// - Integrity frame code 1100, pattern 010101.
// - Bit 27 echoes access kind, resets one.
// - Drain comparator bits, reset 1111.
// - Commanded-on bits from source select.
// - Three-bit gate status per channel, reset zero.
// - Bit zero is odd parity.
// - Status frame code 1101, pattern 010.
// - Latch low-pin overvoltage trip, clear on readout.
// - Live overtemperature bit, reset zero.
// - Latch serial-out overvoltage until readout.
// - Ten-bit temperature conversion result.
// - Ten-bit battery voltage conversion result.
// - High shut-off kills channels one to six.
// - Live high shut-off level plus sticky flag.
// - Outputs restore when high shut-off releases.
// - Low shut-off kills, reports, latches, restores.
// - Supply fault pulls low pin, reset-gated.
// - Overvoltage pulls now, undervoltage after delay.
// - H-bridge channels 7, 8 also shut off.
// - Pin overvoltage releases pull-down until reactivation.
// - Pin overvoltage filter nominal 2.5 us.
//
// Purpose: Shut-off pins, pull-down feedback and two response frames.
// Assumes: Serial shifting lives outside; it loads and confirms frames.
// Notes: Latches clear only for bits that were actually reported.
`timescale 1ns/100ps
`default_nettype none
`include "sso_map.svh"
module sso_top #(
   parameter logic [15:0] UV2_CYCLES = 16'h03e8
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   // Shut-off pins
   input wire logic shutoff_input_high,
   input wire logic shutoff_io_low_in,
   output logic shutoff_io_low_out,
   output logic shutoff_io_low_oe,
   input wire logic reset_pin_low,
   // Analog comparators
   input wire logic low_pin_ov_comp,
   input wire logic supply_ov_filt,
   input wire logic supply_uv_filt,
   input wire logic overtemp_comp,
   input wire logic serial_out_ov_comp,
   input wire logic [3:0] drain_comp,
   // Channel 5 to 8 control, same clock
   input wire logic [3:0] serial_on_command,
   input wire logic [3:0] direct_drive_input,
   input wire logic [3:0] drive_source_select,
   input wire logic [3:0] gate_pu_on,
   input wire logic [3:0] gate_pd_on,
   input wire logic [3:0] pfet_high_side,
   input wire logic hbridge_78,
   // Converter results, same clock
   input wire logic [9:0] temp_code,
   input wire logic temp_valid,
   input wire logic [9:0] battery_voltage_code,
   input wire logic battery_valid,
   // Frame port
   input wire logic frame_req,
   input wire sso_pkg::sso_frame_e frame_sel,
   input wire logic frame_rw,
   input wire logic frame_done,
   output logic [31:0] resp_data,
   output logic resp_valid,
   // Shut-off status
   input wire logic status_readout,
   output logic high_shutoff_level,
   output logic high_shutoff_seen,
   output logic low_shutoff_level,
   output logic low_shutoff_seen,
   output logic low_pin_driven_seen,
   output logic [7:0] chan_off
);
   import sso_pkg::*;

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   logic [11:0] pins_q;     // Synchronised pin levels.
   logic high_lvl;          // High shut-off asserted.
   logic low_lvl;           // Low shut-off asserted.
   logic [3:0] drain;       // Drain comparator view.
   logic [3:0] cmd_on;      // Commanded-on per channel.
   logic [11:0] gate_bits;  // Gate codes, channel 8 on top.
   logic [11:0] next_gate;  // Gate codes to store.
   logic [9:0] temp;        // Temperature result.
   logic [9:0] batt;        // Battery result.
   logic trip_latch;        // Low-pin overvoltage trip flag.
   logic sdo_latch;         // Serial-out overvoltage flag.
   logic snap_trip;         // Trip value sent in loaded frame.
   logic snap_sdo;          // Sdo value sent in loaded frame.
   logic loaded;            // A status frame awaits confirmation.
   logic rw_bit;            // Access kind echoed in bit 27.
   logic clr_sta;           // Confirmed status frame readout.
   logic [30:0] next_body;  // Frame bits 31 to 1.
   logic [7:0] next_off;    // Channel kill vector.

   sso_pd_if pd ();

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   // The low pin enters inverted, so the synchroniser's reset value
   // means not asserted; otherwise its idle-high level would look like
   // a shut-off for the first cycles after reset.
   sso_sync #(.W(12)) u_sync (
      .core_clk(core_clk),
      .nrst(nrst),
      .d({drain_comp, serial_out_ov_comp, overtemp_comp,
          supply_uv_filt, supply_ov_filt, low_pin_ov_comp,
          reset_pin_low, ~shutoff_io_low_in, shutoff_input_high}),
      .q(pins_q)
   );
   assign high_lvl = pins_q[0];
   assign low_lvl = pins_q[1];

   // ----------------------------------------
   // Supply-fault pull-down
   // ----------------------------------------
   assign pd.enable = pins_q[2];
   assign pd.pin_ov = pins_q[3];
   assign pd.req_ov = pins_q[4];
   assign pd.req_uv = pins_q[5];

   sso_pd_guard #(.UV2_CYCLES(UV2_CYCLES)) u_guard (
      .core_clk(core_clk),
      .nrst(nrst),
      .pd(pd)
   );

   // Pin drives low only; the output enable carries the action.
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         shutoff_io_low_out <= 1'b0;
         shutoff_io_low_oe <= 1'b0;
      end else begin
         shutoff_io_low_out <= 1'b0;
         shutoff_io_low_oe <= pd.drive;
      end
   end

   // ----------------------------------------
   // Channel shut-off
   // ----------------------------------------
   // kill channels one to six
   always_comb begin
      next_off = 8'h00;
      if (high_lvl || low_lvl) begin
         next_off = hbridge_78 ? (`SSO_CH16_MASK | `SSO_CH78_MASK)
                               : `SSO_CH16_MASK;
      end
   end

   // automatic restore
   // The kill follows the live level, so release needs no command.
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         chan_off <= 8'h00;
      end else begin
         chan_off <= next_off;
      end
   end

   // ----------------------------------------
   // Shut-off status flags
   // ----------------------------------------
   // live level and sticky flag
   // low level reported and latched
   // A new event in the clearing cycle wins over the clear.
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         high_shutoff_level <= 1'b0;
         high_shutoff_seen <= 1'b0;
         low_shutoff_level <= 1'b0;
         low_shutoff_seen <= 1'b0;
         low_pin_driven_seen <= 1'b0;
      end else begin
         high_shutoff_level <= high_lvl;
         low_shutoff_level <= low_lvl;
         high_shutoff_seen <= high_lvl |
                              (high_shutoff_seen & ~status_readout);
         low_shutoff_seen <= low_lvl |
                             (low_shutoff_seen & ~status_readout);
         low_pin_driven_seen <= pd.drive |
                                (low_pin_driven_seen & ~status_readout);
      end
   end

   // ----------------------------------------
   // Channel integrity state
   // ----------------------------------------
   // NFET code is {0, pd, pu}
   // PFET code is {pd, pu, 0}
   for (genvar i = 0; i < 4; i++) begin : g_gate
      assign next_gate[3*i +: 3] = pfet_high_side[i]
         ? {gate_pd_on[i], gate_pu_on[i], 1'b0}
         : {1'b0, gate_pd_on[i], gate_pu_on[i]};
   end

   // drain view
   // Both polarities read the comparator as is; only meaning differs.
   // commanded-on combine
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         drain <= `SSO_DRAIN_RESET;
         cmd_on <= `SSO_CMD_RESET;
         gate_bits <= `SSO_GATE_RESET;
      end else begin
         drain <= pins_q[11:8];
         cmd_on <= (drive_source_select & serial_on_command) |
                   (~drive_source_select & ~direct_drive_input);
         gate_bits <= next_gate;
      end
   end

   // ----------------------------------------
   // Converter results
   // ----------------------------------------
   // temperature result
   // battery result
   // Cleared at reset although the value has no meaning until a
   // conversion completes.
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         temp <= 10'h000;
         batt <= 10'h000;
      end else begin
         if (temp_valid) begin
            temp <= temp_code;
         end
         if (battery_valid) begin
            batt <= battery_voltage_code;
         end
      end
   end

   // ----------------------------------------
   // Readout-cleared latches
   // ----------------------------------------
   assign clr_sta = frame_done & loaded;

   // clear after confirmed frame
   // Only the reported ones are cleared; set always wins.
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         trip_latch <= 1'b0;
         sdo_latch <= 1'b0;
      end else begin
         trip_latch <= pd.trip |
                       (trip_latch & ~(clr_sta & snap_trip));
         sdo_latch <= pins_q[7] |
                      (sdo_latch & ~(clr_sta & snap_sdo));
      end
   end

   // Remember what the loaded status frame reported.
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         loaded <= 1'b0;
         snap_trip <= 1'b0;
         snap_sdo <= 1'b0;
      end else if (frame_req) begin
         loaded <= (frame_sel == SSO_FR_STATUS);
         snap_trip <= trip_latch;
         snap_sdo <= sdo_latch;
      end else if (frame_done) begin
         loaded <= 1'b0;
      end
   end

   // ----------------------------------------
   // Response frame build
   // ----------------------------------------
   // integrity code and pattern
   always_comb begin
      next_body = {`SSO_INT_CODE, frame_rw, `SSO_INT_PATTERN,
                   drain, cmd_on, gate_bits};
      if (frame_sel == SSO_FR_STATUS) begin
         next_body = {`SSO_STA_CODE, frame_rw, `SSO_STA_PATTERN,
                      trip_latch, pins_q[6],
                      sdo_latch, temp, batt};
      end
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         rw_bit <= `SSO_RW_RESET;
      end else if (frame_req) begin
         rw_bit <= frame_rw;
      end
   end

   // odd parity over the frame, bit zero set when bits 31 to 1 hold an even count of ones
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         resp_data <= `SSO_INT_RESET;
         resp_valid <= 1'b0;
      end else begin
         resp_valid <= frame_req;
         if (frame_req) begin
            resp_data <= {next_body, ~^next_body};
         end
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   property p_int_code;
      @(posedge core_clk) disable iff (!nrst)
      (frame_req && frame_sel == SSO_FR_INTEGRITY) |=>
         resp_data[31:28] == 4'hc && resp_data[26:21] == 6'h15;
   endproperty
   a_int_code: assert property (p_int_code)
      else $error("integrity frame header wrong");

   property p_sta_code;
      @(posedge core_clk) disable iff (!nrst)
      (frame_req && frame_sel == SSO_FR_STATUS) |=>
         resp_data[31:28] == 4'hd && resp_data[26:24] == 3'h2;
   endproperty
   a_sta_code: assert property (p_sta_code)
      else $error("status frame header wrong");

   property p_parity;
      @(posedge core_clk) disable iff (!nrst)
      resp_valid |-> resp_data[0] == ~^resp_data[31:1];
   endproperty
   a_parity: assert property (p_parity)
      else $error("frame parity wrong");

   property p_rw;
      @(posedge core_clk) disable iff (!nrst)
      frame_req |=> resp_data[`SSO_RW_BIT] == $past(frame_rw)
                    && rw_bit == $past(frame_rw);
   endproperty
   a_rw: assert property (p_rw)
      else $error("access bit not echoed");

   property p_high_kill;
      @(posedge core_clk) disable iff (!nrst)
      high_lvl |=> chan_off[5:0] == 6'h3f;
   endproperty
   a_high_kill: assert property (p_high_kill)
      else $error("high shut-off did not kill channels");

   property p_restore;
      @(posedge core_clk) disable iff (!nrst)
      (!high_lvl && !low_lvl) |=> chan_off == 8'h00;
   endproperty
   a_restore: assert property (p_restore)
      else $error("outputs not restored");

   property p_hbridge;
      @(posedge core_clk) disable iff (!nrst)
      ((high_lvl || low_lvl) && hbridge_78) |=> chan_off[7:6] == 2'b11;
   endproperty
   a_hbridge: assert property (p_hbridge)
      else $error("H-bridge pair not shut off");

   property p_seen;
      @(posedge core_clk) disable iff (!nrst)
      (high_shutoff_seen && !status_readout) |=> high_shutoff_seen;
   endproperty
   a_seen: assert property (p_seen)
      else $error("high shut-off flag lost");

   property p_set_wins;
      @(posedge core_clk) disable iff (!nrst)
      (pd.trip || (trip_latch && !clr_sta)) |=> trip_latch;
   endproperty
   a_set_wins: assert property (p_set_wins)
      else $error("trip flag lost");

   c_high: cover property (@(posedge core_clk) $rose(high_lvl));
   c_low: cover property (@(posedge core_clk) $rose(low_lvl));
   c_sta: cover property (@(posedge core_clk) clr_sta && trip_latch);
   c_drive: cover property (@(posedge core_clk) $rose(pd.drive));
endmodule
`default_nettype wire

// >>> pkg/sso_map.svh
// Purpose: Constants for the safety shut-off and status frame block.
// Assumes: A 200 MHz core clock.
// Notes: Field positions are bit indices into a 32-bit frame.
`ifndef SSO_MAP_SVH
`define SSO_MAP_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define SSO_CLK_PERIOD_NS 5
`define SSO_OV_FILT_NS 2500
`define SSO_OV_FILT_CYC \
   ((`SSO_OV_FILT_NS + `SSO_CLK_PERIOD_NS - 1) / `SSO_CLK_PERIOD_NS)

// ----------------------------------------
// Frame codes and patterns
// ----------------------------------------
`define SSO_INT_CODE 4'hc
`define SSO_INT_PATTERN 6'h15
`define SSO_STA_CODE 4'hd
`define SSO_STA_PATTERN 3'h2
`define SSO_INT_RESET 32'hcabe0001

// ----------------------------------------
// Reset values and field positions
// ----------------------------------------
`define SSO_RW_RESET 1'b1
`define SSO_DRAIN_RESET 4'hf
`define SSO_CMD_RESET 4'h0
`define SSO_GATE_RESET 12'h000
`define SSO_RW_BIT 27
`define SSO_CH78_MASK 8'hc0
`define SSO_CH16_MASK 8'h3f

`endif

// >>> pkg/sso_pkg.sv
// Purpose: Shared types of the safety shut-off block.
// Assumes: Nothing beyond the map header.
// Notes: Types only; numbers live in sso_map.svh.
package sso_pkg;
   // Which response frame the host asks for.
   typedef enum logic {SSO_FR_INTEGRITY, SSO_FR_STATUS} sso_frame_e;
   // One channel's gate current-source code.
   typedef logic [2:0] sso_gate_t;
endpackage

// >>> pkg/sso_pd_if.sv
// Purpose: Carrier between the top and the low-pin pull-down guard.
// Assumes: One clock domain.
// Notes: Requests flow in, drive and trip flow back.
`timescale 1ns/100ps
`default_nettype none
interface sso_pd_if;
   logic enable;  // Reset pin high, feedback allowed.
   logic req_ov;  // Filtered logic-supply overvoltage.
   logic req_uv;  // Filtered logic-supply undervoltage.
   logic pin_ov;  // Pin above its overvoltage threshold.
   logic drive;   // Pull-down active.
   logic trip;    // One-cycle pulse when protection fires.
   modport guard (input enable, req_ov, req_uv, pin_ov,
                  output drive, trip);
   modport top (output enable, req_ov, req_uv, pin_ov,
                input drive, trip);
endinterface
`default_nettype wire

// >>> src/sso_sync.sv
// Purpose: Three-stage synchroniser with agreement filter per bit.
// Assumes: Inputs are asynchronous to core_clk.
// Notes: A change counts once stages two and three agree.
`timescale 1ns/100ps
`default_nettype none
module sso_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   // Data
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] s1; // First stage, read only by s2.
   logic [W-1:0] s2; // Second stage.
   logic [W-1:0] s3; // Third stage.

   // ----------------------------------------
   // Per-bit stages
   // ----------------------------------------
   for (genvar i = 0; i < W; i++) begin : g_bit
      // Shift and accept the value only when two stages agree.
      always_ff @(posedge core_clk) begin
         if (!nrst) begin
            s1[i] <= 1'b0;
            s2[i] <= 1'b0;
            s3[i] <= 1'b0;
            q[i] <= 1'b0;
         end else begin
            s1[i] <= d[i];
            s2[i] <= s1[i];
            s3[i] <= s2[i];
            if (s2[i] == s3[i]) begin
               q[i] <= s3[i];
            end
         end
      end
   end
endmodule
`default_nettype wire

// >>> src/sso_pd_guard.sv
// Purpose: Supply-fault pull-down of the low shut-off pin with guard.
// Assumes: Inputs already synchronised to core_clk.
// Notes: Once tripped the pull-down stays off until a new activation.
`timescale 1ns/100ps
`default_nettype none
`include "sso_map.svh"
module sso_pd_guard #(
   parameter logic [15:0] UV2_CYCLES = 16'h03e8
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   // Pull-down carrier
   sso_pd_if.guard pd
);
   logic [15:0] uv_cnt; // Second undervoltage delay counter.
   logic [9:0] ov_cnt;  // Pin overvoltage filter counter.
   logic req_q;         // Request last cycle, for edge detect.
   logic prot;          // Protection active, pull-down released.
   logic fire;          // Filter expired this cycle.
   logic req;           // Pull-down wanted.

   assign req = pd.enable &
                (pd.req_ov | (pd.req_uv && uv_cnt == UV2_CYCLES));
   assign fire = pd.drive & pd.pin_ov &
                 (ov_cnt == 10'(`SSO_OV_FILT_CYC - 1));

   // Undervoltage must persist a further delay before pulling.
   always_ff @(posedge core_clk) begin
      if (!nrst || !pd.req_uv) begin
         uv_cnt <= 16'h0000;
      end else if (uv_cnt != UV2_CYCLES) begin
         uv_cnt <= uv_cnt + 16'h0001;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!nrst || !(pd.drive && pd.pin_ov)) begin
         ov_cnt <= 10'h000;
      end else if (!fire) begin
         ov_cnt <= ov_cnt + 10'h001;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         req_q <= 1'b0;
         prot <= 1'b0;
         pd.trip <= 1'b0;
         pd.drive <= 1'b0;
      end else begin
         req_q <= req;
         pd.trip <= fire;
         if (req && !req_q) begin
            prot <= 1'b0;
         end else if (fire) begin
            prot <= 1'b1;
         end
         pd.drive <= req & ~fire & (~prot | (req & ~req_q));
      end
   end

   property p_release;
      @(posedge core_clk) disable iff (!nrst)
      pd.trip |-> !pd.drive ##1 (!pd.drive || $past(req && !req_q));
   endproperty
   a_release: assert property (p_release)
      else $error("pull-down not released after trip");

   property p_gate;
      @(posedge core_clk) disable iff (!nrst)
      !pd.enable |=> !pd.drive;
   endproperty
   a_gate: assert property (p_gate)
      else $error("pull-down while reset pin low");

   property p_ov_now;
      @(posedge core_clk) disable iff (!nrst)
      (pd.enable && pd.req_ov && !req_q) |=> pd.drive;
   endproperty
   a_ov_now: assert property (p_ov_now)
      else $error("overvoltage pull-down not immediate");

   c_trip: cover property (@(posedge core_clk) pd.trip);
endmodule
`default_nettype wire

// >>> verification/sso_host_pins.sv
// Purpose: Host side of the two shut-off pins, with pull resolution.
// Assumes: The device only pulls the low pin, never drives it high.
// Notes: An undriven pin settles to its pull level, never to a held value.
`timescale 1ns/100ps
`default_nettype none
module sso_host_pins (
   // Host drive
   input wire logic hi_en,
   input wire logic hi_val,
   input wire logic lo_en,
   input wire logic lo_val,
   // Device drive
   input wire logic dev_oe,
   input wire logic dev_out,
   // Resolved pins
   output logic hi_pin,
   output logic lo_pin
);
   assign hi_pin = hi_en ? hi_val : 1'b1;
   assign lo_pin = dev_oe ? dev_out : (lo_en ? lo_val : 1'b0);
endmodule
`default_nettype wire

// >>> verification/test_sso_top.sv
// Purpose: Self-checking bench of the shut-off and frame block.
// Assumes: Inputs change 1 ns after the rising edge.
// Notes: Pin inputs need about five cycles to reach the flags.
`timescale 1ns/100ps
`default_nettype none
`include "sso_map.svh"
module test_sso_top;
   import sso_pkg::*;
   logic core_clk = 0, nrst = 0, hi_en = 1, hi_val = 0, lo_en = 1;
   logic lo_val = 1, rpin = 1, pov = 0, sov = 0, suv = 0, ot = 0, sdo = 0;
   logic [3:0] drain = 4'hf, ser = 0, dir = 4'hf, src = 0;
   logic [3:0] pu = 0, pd = 0, pf = 0;
   logic hb = 0, tv = 0, bv = 0, req = 0, rw = 1, done = 0, rdo = 0;
   logic [9:0] temp = 0, batt = 0;
   sso_frame_e sel = SSO_FR_INTEGRITY;
   logic hi_pin, lo_pin, lo_out, oe, rv, hl, hs, ll, ls, ds;
   logic [31:0] rd;
   logic [7:0] coff;
   int err_count = 0, tests_run = 0;
   initial forever #2.5 core_clk = ~core_clk;
   sso_host_pins sso_host_pins_i (.hi_en(hi_en), .hi_val(hi_val),
      .lo_en(lo_en), .lo_val(lo_val), .dev_oe(oe), .dev_out(lo_out),
      .hi_pin(hi_pin), .lo_pin(lo_pin));
   sso_top #(.UV2_CYCLES(16'h0004)) sso_top_i (.core_clk(core_clk),
      .nrst(nrst), .shutoff_input_high(hi_pin), .shutoff_io_low_in(lo_pin),
      .shutoff_io_low_out(lo_out), .shutoff_io_low_oe(oe),
      .reset_pin_low(rpin), .low_pin_ov_comp(pov), .supply_ov_filt(sov),
      .supply_uv_filt(suv), .overtemp_comp(ot), .serial_out_ov_comp(sdo),
      .drain_comp(drain), .serial_on_command(ser),
      .direct_drive_input(dir), .drive_source_select(src),
      .gate_pu_on(pu), .gate_pd_on(pd), .pfet_high_side(pf),
      .hbridge_78(hb), .temp_code(temp), .temp_valid(tv),
      .battery_voltage_code(batt), .battery_valid(bv), .frame_req(req),
      .frame_sel(sel), .frame_rw(rw), .frame_done(done), .resp_data(rd),
      .resp_valid(rv), .status_readout(rdo), .high_shutoff_level(hl),
      .high_shutoff_seen(hs), .low_shutoff_level(ll),
      .low_shutoff_seen(ls), .low_pin_driven_seen(ds), .chan_off(coff));
   task automatic tk(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic chk_frame(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e) begin
         err_count++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic chk_pin(input logic [7:0] g, input logic [7:0] e);
      chk_frame({24'h0, g}, {24'h0, e});
   endtask
   // Odd parity goes into bit zero.
   function automatic logic [31:0] par(input logic [31:0] f);
      return {f[31:1], ~^f[31:1]};
   endfunction
   function automatic logic [31:0] exp_int(input logic w);
      logic [31:0] f;
      f = {`SSO_INT_CODE, w, `SSO_INT_PATTERN, drain,
           (src & ser) | (~src & ~dir), 13'h0};
      for (int i = 0; i < 4; i++) begin
         f[3*i+1 +: 3] = pf[i] ? {pd[i], pu[i], 1'b0} : {1'b0, pd[i], pu[i]};
      end
      return par(f);
   endfunction
   function automatic logic [31:0] exp_sta(input logic w, input logic t,
         input logic s);
      return par({`SSO_STA_CODE, w, `SSO_STA_PATTERN, t, ot, s, temp, batt,
                  1'b0});
   endfunction
   // One frame request; req stands for exactly one cycle.
   task automatic frame(input sso_frame_e s, input logic w,
         input logic [31:0] e);
      tk(1);
      req = 1;
      sel = s;
      rw = w;
      tk(1);
      req = 0;
      chk_pin({7'h0, rv}, 8'h01);
      chk_frame(rd, e);
   endtask
   task automatic fdone();
      tk(1);
      done = 1;
      tk(1);
      done = 0;
   endtask
   task automatic readout();
      rdo = 1;
      tk(1);
      rdo = 0;
      tk(1);
   endtask
   task automatic t_integrity();
      chk_frame(rd, `SSO_INT_RESET);
      frame(SSO_FR_INTEGRITY, 1, exp_int(1));
      for (int k = 0; k < 2; k++) begin
         pu = k ? 4'hc : 4'ha;
         pd = k ? 4'hc : 4'h5;
         pf = k ? 4'ha : 4'hc;
         drain = k ? 4'h5 : 4'ha;
         ser = k ? 4'hc : 4'h3;
         dir = k ? 4'ha : 4'h5;
         src = k ? 4'h9 : 4'h6;
         tk(8);
         frame(SSO_FR_INTEGRITY, k[0], exp_int(k[0]));
      end
      $display("t_integrity done");
   endtask
   task automatic t_status();
      temp = 10'h2a5;
      batt = 10'h15a;
      tv = 1;
      bv = 1;
      ot = 1;
      sdo = 1;
      tk(1);
      tv = 0;
      bv = 0;
      tk(8);
      frame(SSO_FR_STATUS, 0, exp_sta(0, 0, 1));
      fdone();
      sdo = 0;
      ot = 0;
      tk(8);
      frame(SSO_FR_STATUS, 1, exp_sta(1, 0, 1));
      fdone();
      frame(SSO_FR_STATUS, 1, exp_sta(1, 0, 0));
      $display("t_status done");
   endtask
   task automatic t_pins();
      hi_val = 1;
      tk(8);
      chk_pin(coff, 8'h3f);
      chk_pin({hl, hs, ll, ls}, 8'h0c);
      hb = 1;
      tk(4);
      chk_pin(coff, 8'hff);
      hi_val = 0;
      tk(8);
      chk_pin(coff, 8'h00);
      chk_pin({hl, hs}, 8'h01);
      readout();
      lo_val = 0;
      tk(8);
      chk_pin(coff, 8'hff);
      chk_pin({hl, hs, ll, ls}, 8'h03);
      hb = 0;
      lo_val = 1;
      hi_en = 0;
      tk(8);
      chk_pin(coff, 8'h3f);
      chk_pin({ll, ls}, 8'h01);
      hi_en = 1;
      tk(8);
      readout();
      $display("t_pins done");
   endtask
   task automatic t_pulldown();
      rpin = 0;
      sov = 1;
      tk(10);
      chk_pin({oe, ds}, 8'h00);
      rpin = 1;
      tk(10);
      chk_pin({oe, ds, lo_out, lo_pin}, 8'h0c);
      pov = 1;
      tk(440);
      chk_pin(oe, 8'h01);
      tk(80);
      chk_pin(oe, 8'h00);
      pov = 0;
      tk(10);
      chk_pin(oe, 8'h00);
      frame(SSO_FR_STATUS, 1, exp_sta(1, 1, 0));
      fdone();
      frame(SSO_FR_STATUS, 1, exp_sta(1, 0, 0));
      sov = 0;
      tk(10);
      sov = 1;
      tk(10);
      chk_pin(oe, 8'h01);
      sov = 0;
      tk(10);
      suv = 1;
      tk(3);
      chk_pin(oe, 8'h00);
      tk(15);
      chk_pin(oe, 8'h01);
      suv = 0;
      $display("t_pulldown done");
   endtask
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   initial begin
      tk(4);
      nrst = 1;
      tk(8);
      t_integrity();
      t_status();
      t_pins();
      t_pulldown();
      report_and_stop();
   end
   initial begin
      #40000;
      err_count++;
      report_and_stop();
   end
endmodule
`default_nettype wire
